// ==== hdl/tmcap_defines.vh ====
// constants of the 16-bit timer with input capture
// Behaviour
// - counter ticks only when clock select nonzero
// - prescaled first tick within 1..N cycles
// - free prescaler shared, reset restarts all
// - 16-bit counter clears, increments or decrements
// - low-byte read latches counter high into temp
// - low-byte write loads temp:data at once
// - software counter write beats counting
// - counter accessible with or without tick
// - overflow flag set per waveform mode
// - selected edge copies counter into capture
// - capture flag set with capture copy
// - enabled capture flag requests interrupt, auto-clears
// - writing one clears capture flag
// - capture low read latches high into temp
// - capture writable only in capture-top modes
// - comparator select replaces pin as trigger
// - filter changes after four equal samples
// - filter adds five system cycles delay
// - capture disabled in capture-top modes
// - new capture overwrites unread value
// - one temp byte shared by all 16-bit registers
// - bottom at 0x0000, max at 0xFFFF
`ifndef TMCAP_DEFINES_VH
`define TMCAP_DEFINES_VH

// ***********************************************************
// register byte addresses
// ***********************************************************
`define TMCAP_OFF_CTRLA   8'h00
`define TMCAP_OFF_CTRLB   8'h04
`define TMCAP_OFF_CNTL    8'h08
`define TMCAP_OFF_CNTH    8'h0C
`define TMCAP_OFF_CAPL    8'h10
`define TMCAP_OFF_CAPH    8'h14
`define TMCAP_OFF_STAT    8'h18
`define TMCAP_OFF_IRQEN   8'h1C
`define TMCAP_OFF_CMP     8'h20
`define TMCAP_OFF_PRESRST 8'h24

// ***********************************************************
// field positions
// ***********************************************************
`define TMCAP_B_CS_LO     0
`define TMCAP_B_CS_HI     2
`define TMCAP_B_WGMB_LO   3
`define TMCAP_B_WGMB_HI   4
`define TMCAP_B_EDGE      6
`define TMCAP_B_NFE       7
`define TMCAP_B_WGMA_LO   0
`define TMCAP_B_WGMA_HI   1
`define TMCAP_B_OVF       0
`define TMCAP_B_CAPF      1
`define TMCAP_B_COMPARATOR_CAPTURE_SELECT      0
`define TMCAP_B_PRES      0

// ***********************************************************
// reset values and counts
// ***********************************************************
`define TMCAP_RST_BYTE    8'h00
`define TMCAP_RST_CNT     16'h0000
`define TMCAP_BOTTOM      16'h0000
`define TMCAP_MAX         16'hFFFF
`define TMCAP_FILT_LEN    4
`define TMCAP_PRES_W      10

`endif

// ==== hdl/tmcap_filter.v ====
// capture input noise filter
`timescale 1ns/1ns
module tmcap_filter #(
  parameter LEN = 4
) (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // control
  input  wire enable,
  // signal
  input  wire din,
  output wire dout
);
  reg [LEN-1:0] hist_q;
  reg           filt_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_q <= {LEN{1'b0}};
      filt_q <= 1'b0;
    end else begin
      hist_q <= {hist_q[LEN-2:0], din};
      // output follows only when all samples agree
      if (&hist_q) begin
        filt_q <= 1'b1;
      end else if (~|hist_q) begin
        filt_q <= 1'b0;
      end
    end
  end

  // filtered path is on the system clock, adding the sample delay
  assign dout = enable ? filt_q : din;
endmodule // tmcap_filter

// ==== hdl/tmcap_prescaler.v ====
// free-running shared prescaler with tick taps
`timescale 1ns/1ns
module tmcap_prescaler #(
  parameter WIDTH = 10
) (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // control
  input  wire presReset,
  // tick taps
  output wire tap8,
  output wire tap64,
  output wire tap256,
  output wire tap1024
);
  reg [WIDTH-1:0] divCnt_q;

  // runs regardless of any clock select; reset restarts every tap
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= {WIDTH{1'b0}};
    end else if (presReset) begin
      divCnt_q <= {WIDTH{1'b0}};
    end else begin
      divCnt_q <= divCnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // a tap pulses once each N cycles; first tick lands 1..N after enable
  assign tap8    = &divCnt_q[2:0];
  assign tap64   = &divCnt_q[5:0];
  assign tap256  = &divCnt_q[7:0];
  assign tap1024 = &divCnt_q[9:0];
endmodule // tmcap_prescaler

// ==== hdl/tmcap_timer.v ====
// 16-bit timer counter with input capture behind an APB slave
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "tmcap_defines.vh"
module tmcap_timer (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // pins and comparator
  input  wire        capturePin,
  input  wire        comparatorOutput,
  input  wire        externalCountPin,
  // status
  output wire        overflowIrq,
  output wire        captureIrq,
  output wire        bottomFlag,
  output wire        maxFlag,
  input  wire        captureIrqAck
);
  // ***********************************************************
  // registers
  // ***********************************************************
  reg  [7:0]  ctrlA_q;
  reg  [7:0]  ctrlB_q;
  reg  [15:0] count_q;
  reg  [15:0] capture_q;
  reg  [7:0]  temp_q;
  reg         ovf_q;
  reg         capF_q;
  reg  [1:0]  irqEn_q;
  reg         comparator_capture_select_q;
  reg         extSync_q;
  reg         extPrev_q;
  reg         trigPrev_q;
  reg  [15:0] count_d;

  wire [2:0]  clockSourceSelect = ctrlB_q[`TMCAP_B_CS_HI:`TMCAP_B_CS_LO];
  wire [3:0]  waveformModeSelect = {ctrlB_q[`TMCAP_B_WGMB_HI:`TMCAP_B_WGMB_LO],
                                    ctrlA_q[`TMCAP_B_WGMA_HI:`TMCAP_B_WGMA_LO]};
  wire        noiseFilterEnable = ctrlB_q[`TMCAP_B_NFE];
  wire        edgeRising        = ctrlB_q[`TMCAP_B_EDGE];

  // ***********************************************************
  // apb decode
  // ***********************************************************
  wire access  = psel & penable;
  wire wrEn    = access & pwrite;
  // read side effects on the setup edge, where prdata samples the same count
  wire rdEn    = psel & ~penable & ~pwrite;

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  function capTopMode;
    input [3:0] m;
    begin
      capTopMode = (m == 4'h8) | (m == 4'hA) | (m == 4'hC) | (m == 4'hE);
    end
  endfunction

  function dualSlope;
    input [3:0] m;
    begin
      dualSlope = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hB);
    end
  endfunction

  function known;
    input [7:0] a;
    begin
      known = hit(a, `TMCAP_OFF_CTRLA) | hit(a, `TMCAP_OFF_CTRLB) |
              hit(a, `TMCAP_OFF_CNTL) | hit(a, `TMCAP_OFF_CNTH) |
              hit(a, `TMCAP_OFF_CAPL) | hit(a, `TMCAP_OFF_CAPH) |
              hit(a, `TMCAP_OFF_STAT) | hit(a, `TMCAP_OFF_IRQEN) |
              hit(a, `TMCAP_OFF_CMP) | hit(a, `TMCAP_OFF_PRESRST);
    end
  endfunction

  assign pready  = 1'b1;
  assign pslverr = access & ~known(paddr);

  wire wrCntL  = wrEn & hit(paddr, `TMCAP_OFF_CNTL);
  wire rdCntL  = rdEn & hit(paddr, `TMCAP_OFF_CNTL);
  wire wrCapL  = wrEn & hit(paddr, `TMCAP_OFF_CAPL);
  wire rdCapL  = rdEn & hit(paddr, `TMCAP_OFF_CAPL);
  wire wrHigh  = wrEn & (hit(paddr, `TMCAP_OFF_CNTH) | hit(paddr, `TMCAP_OFF_CAPH));
  wire capTop  = capTopMode(waveformModeSelect);
  wire presRst = wrEn & hit(paddr, `TMCAP_OFF_PRESRST) & pwdata[`TMCAP_B_PRES];

  // ***********************************************************
  // clock select
  // ***********************************************************
  wire tap8;
  wire tap64;
  wire tap256;
  wire tap1024;

  tmcap_prescaler #(
    .WIDTH (`TMCAP_PRES_W)
  ) uPres (
    .clk       (clk),
    .rst_n     (rst_n),
    .presReset (presRst),
    .tap8      (tap8),
    .tap64     (tap64),
    .tap256    (tap256),
    .tap1024   (tap1024)
  );

  reg timerTick;
  always @* begin
    case (clockSourceSelect)
      3'h0:    timerTick = 1'b0;
      3'h1:    timerTick = 1'b1;
      3'h2:    timerTick = tap8;
      3'h3:    timerTick = tap64;
      3'h4:    timerTick = tap256;
      3'h5:    timerTick = tap1024;
      3'h6:    timerTick = extPrev_q & ~extSync_q;
      3'h7:    timerTick = ~extPrev_q & extSync_q;
      default: timerTick = 1'b0;
    endcase
  end

  // ***********************************************************
  // counter
  // ***********************************************************
  reg  dirDown_q;
  wire atBottom = (count_q == `TMCAP_BOTTOM);
  wire atMax    = (count_q == `TMCAP_MAX);
  wire [15:0] topVal = capTop ? capture_q : `TMCAP_MAX;
  wire atTop    = (count_q == topVal);
  wire dual     = dualSlope(waveformModeSelect);

  assign bottomFlag = atBottom;
  assign maxFlag    = atMax;

  reg ovfSet;
  always @* begin
    count_d = count_q;
    ovfSet  = 1'b0;
    if (wrCntL) begin
      count_d = {temp_q, pwdata[7:0]};
    end else if (timerTick) begin
      if (dual) begin
        count_d = dirDown_q ? count_q - 16'h0001 : count_q + 16'h0001;
        ovfSet  = dirDown_q & (count_q == 16'h0001);
      end else if (atTop) begin
        count_d = `TMCAP_BOTTOM;
        ovfSet  = 1'b1;
      end else begin
        count_d = count_q + 16'h0001;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q   <= `TMCAP_RST_CNT;
      dirDown_q <= 1'b0;
    end else begin
      count_q <= count_d;
      if (!wrCntL && timerTick && dual) begin
        if (count_d == topVal) begin
          dirDown_q <= 1'b1;
        end else if (count_d == `TMCAP_BOTTOM) begin
          dirDown_q <= 1'b0;
        end
      end
    end
  end

  // ***********************************************************
  // capture path
  // ***********************************************************
  wire trigRaw = comparator_capture_select_q ? comparatorOutput : capturePin;
  wire trigFilt;

  tmcap_filter #(
    .LEN (`TMCAP_FILT_LEN)
  ) uFilt (
    .clk    (clk),
    .rst_n  (rst_n),
    .enable (noiseFilterEnable),
    .din    (trigRaw),
    .dout   (trigFilt)
  );

  wire edgeSeen = edgeRising ? (trigFilt & ~trigPrev_q)
                             : (~trigFilt & trigPrev_q);
  wire capEvent = edgeSeen & ~capTop;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extSync_q  <= 1'b0;
      extPrev_q  <= 1'b0;
      trigPrev_q <= 1'b0;
      capture_q  <= `TMCAP_RST_CNT;
    end else begin
      extSync_q  <= externalCountPin;
      extPrev_q  <= extSync_q;
      trigPrev_q <= trigFilt;
      if (capEvent) begin
        capture_q <= count_q;
      end else if (wrCapL && capTop) begin
        capture_q <= {temp_q, pwdata[7:0]};
      end
    end
  end

  // ***********************************************************
  // control, flags and shared temp
  // ***********************************************************
  wire statWr = wrEn & hit(paddr, `TMCAP_OFF_STAT);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlA_q <= `TMCAP_RST_BYTE;
      ctrlB_q <= `TMCAP_RST_BYTE;
      irqEn_q <= 2'h0;
      comparator_capture_select_q  <= 1'b0;
      temp_q  <= `TMCAP_RST_BYTE;
      ovf_q   <= 1'b0;
      capF_q  <= 1'b0;
    end else begin
      if (wrEn && hit(paddr, `TMCAP_OFF_CTRLA)) begin
        ctrlA_q <= pwdata[7:0];
      end
      if (wrEn && hit(paddr, `TMCAP_OFF_CTRLB)) begin
        ctrlB_q <= pwdata[7:0];
      end
      if (wrEn && hit(paddr, `TMCAP_OFF_IRQEN)) begin
        irqEn_q <= pwdata[1:0];
      end
      if (wrEn && hit(paddr, `TMCAP_OFF_CMP)) begin
        comparator_capture_select_q <= pwdata[`TMCAP_B_COMPARATOR_CAPTURE_SELECT];
      end
      // one temp byte for all 16-bit registers
      if (wrHigh) begin
        temp_q <= pwdata[7:0];
      end else if (rdCntL) begin
        temp_q <= count_q[15:8];
      end else if (rdCapL) begin
        temp_q <= capture_q[15:8];
      end
      // set wins over clear
      if (ovfSet && timerTick && !wrCntL) begin
        ovf_q <= 1'b1;
      end else if (statWr && pwdata[`TMCAP_B_OVF]) begin
        ovf_q <= 1'b0;
      end
      if (capEvent) begin
        capF_q <= 1'b1;
      end else if ((statWr && pwdata[`TMCAP_B_CAPF]) ||
                   (captureIrqAck && irqEn_q[1])) begin
        capF_q <= 1'b0;
      end
    end
  end

  assign overflowIrq = ovf_q & irqEn_q[0];
  assign captureIrq  = capF_q & irqEn_q[1];

  // ***********************************************************
  // read data
  // ***********************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `TMCAP_OFF_CTRLA: prdata <= {24'h000000, ctrlA_q};
        `TMCAP_OFF_CTRLB: prdata <= {24'h000000, ctrlB_q};
        `TMCAP_OFF_CNTL:  prdata <= {24'h000000, count_q[7:0]};
        `TMCAP_OFF_CNTH:  prdata <= {24'h000000, temp_q};
        `TMCAP_OFF_CAPL:  prdata <= {24'h000000, capture_q[7:0]};
        `TMCAP_OFF_CAPH:  prdata <= {24'h000000, temp_q};
        `TMCAP_OFF_STAT:  prdata <= {30'h00000000, capF_q, ovf_q};
        `TMCAP_OFF_IRQEN: prdata <= {30'h00000000, irqEn_q};
        `TMCAP_OFF_CMP:   prdata <= {31'h00000000, comparator_capture_select_q};
        default:          prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // tmcap_timer

// ==== verification/tb.sv ====
// self-checking bench of the timer with input capture
`timescale 1ns/1ns
module tb;
  reg         clk              = 1'b0;
  reg         rst_n            = 1'b0;
  reg         capturePin       = 1'b0;
  reg         comparatorOutput = 1'b0;
  reg         externalCountPin = 1'b0;
  reg         captureIrqAck    = 1'b0;
  wire        psel, penable, pwrite, pready, pslverr;
  wire [7:0]  paddr;
  wire [31:0] pwdata, prdata;
  wire        overflowIrq, captureIrq, bottomFlag, maxFlag;
  integer     fail_count = 0;
  integer     n_compared = 0;
  integer     i, l0, l1;
  reg  [7:0]  b;
  reg  [15:0] v;

  always #20 clk = ~clk;

  tmcap_timer DUT (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .capturePin, .comparatorOutput, .externalCountPin, .overflowIrq, .captureIrq,
    .bottomFlag, .maxFlag, .captureIrqAck
  );
  tmcap_cpu_model cpu (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata);

  task chkV(input [15:0] e, input [15:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task chkF(input e, input g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    cpu.xfer(1'b1, a, d, b);
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // negedges from a pin change until the capture request shows
  task lat(output integer n);
    n = 0;
    while (captureIrq !== 1'b1 && n < 20) begin
      @(negedge clk);
      n = n + 1;
    end
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count = fail_count + 1;
    complete_run;
  end

  // ****
  // tests
  // ****
  initial begin
    cyc(8);
    rst_n <= 1'b1;
    for (i = 0; i < 11; i = i + 1) begin
      cpu.xfer(1'b0, 8'(i * 4), 8'h00, b);
      chkV(16'h0000, {8'h00, b});
    end
    chkF(1'b1, bottomFlag);
    cpu.wr16(8'h0C, 16'h1234);
    wr(8'h0C, 8'h77);
    cyc(20);
    cpu.rd16(8'h08, v);
    chkV(16'h1234, v);
    $display("test access done");
    cpu.wr16(8'h0C, 16'hFFFF);
    @(negedge clk);
    chkF(1'b1, maxFlag);
    cpu.wr16(8'h0C, 16'hFFFD);
    wr(8'h1C, 8'h01);
    wr(8'h04, 8'h01);
    repeat (20) if (overflowIrq !== 1'b1) @(negedge clk);
    chkF(1'b1, overflowIrq);
    wr(8'h04, 8'h00);
    wr(8'h18, 8'h01);
    @(negedge clk);
    chkF(1'b0, overflowIrq);
    cpu.wr16(8'h0C, 16'h0000);
    wr(8'h24, 8'h01);
    wr(8'h04, 8'h02);
    cyc(12);
    wr(8'h04, 8'h00);
    cpu.rd16(8'h08, v);
    chkF(1'b1, v >= 16'h0001 && v <= 16'h0002);
    cpu.wr16(8'h0C, 16'h0000);
    wr(8'h04, 8'h07);
    repeat (3) begin
      externalCountPin <= 1'b1;
      cyc(2);
      externalCountPin <= 1'b0;
      cyc(2);
    end
    wr(8'h04, 8'h00);
    cpu.rd16(8'h08, v);
    chkV(16'h0003, v);
    $display("test count done");
    wr(8'h1C, 8'h02);
    cpu.wr16(8'h0C, 16'hABCD);
    wr(8'h04, 8'h40);
    capturePin <= 1'b1;
    lat(l0);
    chkF(1'b1, captureIrq);
    cpu.wr16(8'h0C, 16'h1111);
    wr(8'h04, 8'h00);
    capturePin <= 1'b0;
    cyc(16);
    cpu.rd16(8'h10, v);
    chkV(16'h1111, v);
    captureIrqAck <= 1'b1;
    @(posedge clk);
    captureIrqAck <= 1'b0;
    @(negedge clk);
    chkF(1'b0, captureIrq);
    wr(8'h20, 8'h01);
    wr(8'h18, 8'h02);
    wr(8'h04, 8'h40);
    capturePin <= 1'b1;
    cyc(16);
    @(negedge clk);
    chkF(1'b0, captureIrq);
    comparatorOutput <= 1'b1;
    lat(l1);
    chkF(1'b1, captureIrq);
    wr(8'h18, 8'h00);
    @(negedge clk);
    chkF(1'b1, captureIrq);
    wr(8'h18, 8'h02);
    @(negedge clk);
    chkF(1'b0, captureIrq);
    wr(8'h20, 8'h00);
    wr(8'h18, 8'h02);
    $display("test capture done");
    wr(8'h04, 8'h80);
    capturePin <= 1'b0;
    cyc(3);
    capturePin <= 1'b1;
    cyc(16);
    @(negedge clk);
    chkF(1'b0, captureIrq);
    @(posedge clk);
    capturePin <= 1'b0;
    lat(l1);
    chkF(1'b1, l1 - l0 >= 4 && l1 - l0 <= 5);
    wr(8'h04, 8'h10);
    wr(8'h18, 8'h02);
    capturePin <= 1'b1;
    cyc(16);
    capturePin <= 1'b0;
    cyc(16);
    @(negedge clk);
    chkF(1'b0, captureIrq);
    wr(8'h0C, 8'h5A);
    wr(8'h10, 8'h66);
    cpu.rd16(8'h10, v);
    chkV(16'h5A66, v);
    wr(8'h04, 8'h00);
    cpu.wr16(8'h14, 16'h7788);
    cpu.rd16(8'h10, v);
    chkV(16'h5A66, v);
    $display("test filter and modes done");
    complete_run;
  end
endmodule // tb

// ==== verification/tmcap_cpu_model.sv ====
// processor model issuing byte accesses on apb
`timescale 1ns/1ns
module tmcap_cpu_model (
  // clock
  input  wire        clk,
  // apb master
  output reg         psel    = 1'b0,
  output reg         penable = 1'b0,
  output reg         pwrite  = 1'b0,
  output reg  [7:0]  paddr   = 8'h00,
  output reg  [31:0] pwdata  = 32'h00000000,
  input  wire        pready,
  input  wire [31:0] prdata
);
  // ****
  // bus cycles
  // ****
  task automatic xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata[7:0];
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~pwdata;
  endtask
  // high byte into the shared temp first, low byte commits
  task automatic wr16(input [7:0] ah, input [15:0] v);
    reg [7:0] q;
    xfer(1'b1, ah, v[15:8], q);
    xfer(1'b1, ah - 8'h04, v[7:0], q);
  endtask
  task automatic rd16(input [7:0] al, output [15:0] v);
    xfer(1'b0, al, 8'h00, v[7:0]);
    xfer(1'b0, al + 8'h04, 8'h00, v[15:8]);
  endtask
endmodule // tmcap_cpu_model

// ==== verification/tmcap_timer_assertions.sv ====
// port assertions of the timer with input capture
`timescale 1ns/1ns
module tmcap_chk (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // apb slave
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // pins and status
  input wire        capturePin,
  input wire        comparatorOutput,
  input wire        overflowIrq,
  input wire        captureIrq,
  input wire        bottomFlag,
  input wire        maxFlag,
  input wire        captureIrqAck
);
  reg [3:0] quiet_q;
  // cycles since the last trigger change, bus access or acknowledge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_q <= 4'h0;
    end else if (psel | captureIrqAck | $changed(capturePin) | $changed(comparatorOutput)) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  // ****
  // port relations
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  zero_wait_a: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  err_access_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  unmapped_err_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && penable && paddr <= 8'h24
    && paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped access refused");
  read_hold_a: assert property (psel && penable && !pwrite ##1 !psel |-> $stable(prdata))
    else $error("read data moved");
  flag_excl_a: assert property (!(bottomFlag && maxFlag))
    else $error("bottom and max together");
  ack_clear_a: assert property (captureIrq && captureIrqAck |=> !captureIrq)
    else $error("ack did not clear capture");
  quiet_cap_a: assert property (quiet_q == 4'hF |-> $stable(captureIrq))
    else $error("capture with no trigger");
  ovf_cause_a: assert property ($rose(overflowIrq) |-> $past(maxFlag) ||
    $past(bottomFlag) || bottomFlag || ($past(penable) && $past(pwrite)))
    else $error("overflow with no wrap");
  cap_seen_c: cover property ($rose(captureIrq));
  ovf_seen_c: cover property ($rose(overflowIrq));
  err_seen_c: cover property (pslverr);
endmodule // tmcap_chk

bind tmcap_timer tmcap_chk uChk (
  .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
  .capturePin, .comparatorOutput, .overflowIrq, .captureIrq, .bottomFlag, .maxFlag,
  .captureIrqAck
);
